// ===== core/hrfc_consts.vh
// Constants for the host read feature control block
`ifndef HRFC_CONSTS_VH
`define HRFC_CONSTS_VH

// Register addresses (7-bit register pointer)
`define HRFC_ADDR_XLO 7'h02
`define HRFC_ADDR_XHI 7'h03
`define HRFC_ADDR_YLO 7'h04
`define HRFC_ADDR_YHI 7'h05
`define HRFC_ADDR_ZLO 7'h06
`define HRFC_ADDR_ZHI 7'h07
`define HRFC_ADDR_STAT1 7'h08
`define HRFC_ADDR_INTST 7'h09
`define HRFC_ADDR_FEAT 7'h0E

// Feature register reset value and bit positions
`define HRFC_FEAT_RESET 8'h00
`define HRFC_BIT_WRAP 0
`define HRFC_BIT_BURST 1
`define HRFC_BIT_SPI_TOK 2
`define HRFC_BIT_FIFO_TOK 3
`define HRFC_BIT_WRCLR 4
`define HRFC_BIT_STREAM 5
`define HRFC_BIT_TRIG_POL 6
`define HRFC_BIT_TRIG_EN 7

// Serial header layout: read flag on top, register pointer below
`define HRFC_HDR_RW_BIT 7

// Largest number of samples drained in one transaction
`define HRFC_MAX_SAMPLES 6'h20

// Bits shifted per serial byte, less one
`define HRFC_LAST_BIT 3'h7

`endif

// ===== core/hrfc_spi_link.v
// Oversampled SPI shift engine for the host read feature control block
`timescale 1ns/1ps
`include "hrfc_consts.vh"

module hrfc_spi_link (
    input wire clk,
    input wire rst_n,
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    input wire sdio_in,
    input wire link_enable,
    input wire three_wire,
    input wire drive_3w,
    input wire [7:0] token_byte,
    input wire [7:0] tx_byte,
    input wire tx_load,
    output reg [7:0] rx_byte_ff,
    output reg rx_done_ff,
    output reg start_ff,
    output wire frame_active,
    output reg sdo_ff,
    output reg sdo_oe_ff
);

    // Order: sck, cs_n, mosi, sdio
    reg [3:0] in_s1_ff;
    reg [3:0] in_s2_ff;
    reg [1:0] prev_ff;
    reg [6:0] rx_sh_ff;
    reg [2:0] bit_cnt_ff;
    reg [7:0] tx_sh_ff;

    wire sck_s = in_s2_ff[3];
    wire cs_n_s = in_s2_ff[2];
    wire din = three_wire ? in_s2_ff[0] : in_s2_ff[1];
    wire start = link_enable && !cs_n_s && prev_ff[0];
    wire sck_rise = frame_active && sck_s && !prev_ff[1];
    wire sck_fall = frame_active && !sck_s && prev_ff[1];

    assign frame_active = link_enable && !cs_n_s;

    always @(posedge clk) begin
        if (!rst_n) begin
            in_s1_ff <= 4'h4;
            in_s2_ff <= 4'h4;
            prev_ff <= 2'h1;
            rx_sh_ff <= 7'h00;
            bit_cnt_ff <= 3'h0;
            rx_byte_ff <= 8'h00;
            rx_done_ff <= 1'b0;
            start_ff <= 1'b0;
            tx_sh_ff <= 8'h00;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            in_s1_ff <= {spi_sck, spi_cs_n, spi_mosi, sdio_in};
            in_s2_ff <= in_s1_ff;
            prev_ff <= {sck_s, cs_n_s};
            rx_done_ff <= 1'b0;
            start_ff <= start;
            sdo_oe_ff <= frame_active && (three_wire ? drive_3w : 1'b1);
            if (start) begin
                // First bit of the first byte must be out before the first rising edge
                bit_cnt_ff <= 3'h0;
                sdo_ff <= token_byte[7];
                tx_sh_ff <= {token_byte[6:0], 1'b0};
            end else begin
                if (sck_rise) begin
                    rx_sh_ff <= {rx_sh_ff[5:0], din};
                    bit_cnt_ff <= bit_cnt_ff + 3'h1;
                    if (bit_cnt_ff == `HRFC_LAST_BIT) begin
                        rx_byte_ff <= {rx_sh_ff, din};
                        rx_done_ff <= 1'b1;
                    end
                end
                if (tx_load) begin
                    tx_sh_ff <= tx_byte;
                end else if (sck_fall) begin
                    sdo_ff <= tx_sh_ff[7];
                    tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                end
            end
        end
    end

endmodule // hrfc_spi_link

// ===== core/hrfc_read_feature.v
// Read feature control register with burst pointer, status tokens and interrupt clearing
`timescale 1ns/1ps
`include "hrfc_consts.vh"

module hrfc_read_feature #(
    parameter [5:0] MAX_SAMPLES = `HRFC_MAX_SAMPLES
) (
    input wire clk,
    input wire rst_n,
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_mosi,
    input wire serial_out_pin_in,
    output wire serial_out_pin_out,
    output wire serial_out_pin_oe,
    input wire i2c_select,
    input wire spi3_select,
    input wire twi_ptr_load,
    input wire [7:0] twi_ptr_data,
    input wire twi_wr,
    input wire [7:0] twi_wdata,
    input wire twi_rd,
    output reg [7:0] twi_rdata_ff,
    input wire [15:0] fifo_x,
    input wire [15:0] fifo_y,
    input wire [15:0] fifo_z,
    input wire res_14bit,
    input wire interrupt_pending_flag,
    input wire queue_threshold_flag,
    input wire fifo_full_flag,
    input wire fifo_empty_flag,
    input wire [7:0] status1,
    input wire [7:0] int_status,
    input wire [7:0] sys_status,
    output reg int_clear_ff,
    output reg fifo_pop_ff,
    output reg [7:0] read_feature_control_ff,
    output wire outside_trigger_enable,
    output wire outside_trigger_polarity,
    output wire fifo_stream_enable
);

    reg [6:0] ptr_ff;
    reg spi_hdr_ff;
    reg spi_rd_ff;
    reg [5:0] samples_ff;
    reg [15:0] hold_x_ff;
    reg [15:0] hold_y_ff;
    reg [15:0] hold_z_ff;
    reg [7:0] tx_byte_ff;
    reg tx_load_ff;

    reg [7:0] nxt_rd_byte;
    reg [15:0] nxt_z;

    wire [7:0] spi_rx_byte;
    wire spi_rx_done;
    wire spi_start;
    wire spi_active;

    wire wrap_sel = read_feature_control_ff[`HRFC_BIT_WRAP];
    wire burst_sel = read_feature_control_ff[`HRFC_BIT_BURST];
    wire spi_tok_sel = read_feature_control_ff[`HRFC_BIT_SPI_TOK];
    wire fifo_tok_sel = read_feature_control_ff[`HRFC_BIT_FIFO_TOK];
    wire two_wire_write_clear_select = read_feature_control_ff[`HRFC_BIT_WRCLR];

    // Write-clear only takes effect when the I2C interface is selected
    wire twi_wr_clears = two_wire_write_clear_select && i2c_select;

    // SPI owns the access path while its frame is open
    wire twi_ok = !spi_active;
    wire twi_rd_ok = twi_rd && twi_ok;
    wire twi_wr_ok = twi_wr && twi_ok;
    wire twi_ptr_ok = twi_ptr_load && twi_ok;

    wire spi_hdr = spi_rx_done && spi_hdr_ff;
    wire spi_data = spi_rx_done && !spi_hdr_ff;
    wire spi_hdr_rd = spi_hdr && spi_rx_byte[`HRFC_HDR_RW_BIT];
    wire spi_ld = spi_hdr_rd || (spi_data && spi_rd_ff);
    wire spi_wr = spi_data && !spi_rd_ff;

    // Byte fetch for either interface
    wire ld = spi_ld || twi_rd_ok;
    wire [6:0] ld_addr = spi_hdr ? spi_rx_byte[6:0] : ptr_ff;

    // A new sample is taken atomically when its first byte is fetched
    wire smp_ok = (burst_sel || (samples_ff == 6'h00)) && (samples_ff < MAX_SAMPLES);
    wire cap_now = ld && (ld_addr == `HRFC_ADDR_XLO) && smp_ok;

    wire [3:0] fifo_flags = {interrupt_pending_flag, queue_threshold_flag,
                             fifo_full_flag, fifo_empty_flag};
    wire [15:0] smp_x = cap_now ? fifo_x : hold_x_ff;
    wire [15:0] smp_y = cap_now ? fifo_y : hold_y_ff;
    wire [15:0] smp_z = cap_now ? nxt_z : hold_z_ff;

    // Token on the first byte only for 4-wire SPI with the token enabled
    wire [7:0] token_byte = (spi_tok_sel && !spi3_select) ? sys_status : 8'h00;

    assign outside_trigger_enable = read_feature_control_ff[`HRFC_BIT_TRIG_EN];
    assign outside_trigger_polarity = read_feature_control_ff[`HRFC_BIT_TRIG_POL];
    assign fifo_stream_enable = read_feature_control_ff[`HRFC_BIT_STREAM];

    function [6:0] hrfc_next;
        input [6:0] addr;
        input wrap;
        begin
            if (!wrap && addr == `HRFC_ADDR_ZHI) begin
                hrfc_next = `HRFC_ADDR_XLO;
            end else if (wrap && addr == `HRFC_ADDR_INTST) begin
                hrfc_next = `HRFC_ADDR_XLO;
            end else begin
                hrfc_next = addr + 7'h01;
            end
        end
    endfunction

    // Z word with optional FIFO status token
    always @* begin
        if (!fifo_tok_sel) begin
            nxt_z = fifo_z;
        end else if (res_14bit) begin
            nxt_z = {fifo_z[15:4], fifo_flags};
        end else begin
            nxt_z = {fifo_flags, fifo_z[11:0]};
        end
    end

    // Read data for the fetched address
    always @* begin
        case (ld_addr)
            `HRFC_ADDR_XLO: begin
                nxt_rd_byte = smp_x[7:0];
            end
            `HRFC_ADDR_XHI: begin
                nxt_rd_byte = smp_x[15:8];
            end
            `HRFC_ADDR_YLO: begin
                nxt_rd_byte = smp_y[7:0];
            end
            `HRFC_ADDR_YHI: begin
                nxt_rd_byte = smp_y[15:8];
            end
            `HRFC_ADDR_ZLO: begin
                nxt_rd_byte = smp_z[7:0];
            end
            `HRFC_ADDR_ZHI: begin
                nxt_rd_byte = smp_z[15:8];
            end
            `HRFC_ADDR_STAT1: begin
                nxt_rd_byte = status1;
            end
            `HRFC_ADDR_INTST: begin
                nxt_rd_byte = int_status;
            end
            `HRFC_ADDR_FEAT: begin
                nxt_rd_byte = read_feature_control_ff;
            end
            default: begin
                nxt_rd_byte = 8'h00;
            end
        endcase
    end

    hrfc_spi_link u_link (
        .clk(clk),
        .rst_n(rst_n),
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .sdio_in(serial_out_pin_in),
        .link_enable(!i2c_select),
        .three_wire(spi3_select),
        .drive_3w(spi_rd_ff && !spi_hdr_ff),
        .token_byte(token_byte),
        .tx_byte(tx_byte_ff),
        .tx_load(tx_load_ff),
        .rx_byte_ff(spi_rx_byte),
        .rx_done_ff(spi_rx_done),
        .start_ff(spi_start),
        .frame_active(spi_active),
        .sdo_ff(serial_out_pin_out),
        .sdo_oe_ff(serial_out_pin_oe)
    );

    // SPI header tracking
    always @(posedge clk) begin
        if (!rst_n) begin
            spi_hdr_ff <= 1'b1;
            spi_rd_ff <= 1'b0;
        end else if (spi_start || !spi_active) begin
            // Idle between frames so a 3-wire pin is not driven at the next select
            spi_hdr_ff <= 1'b1;
            spi_rd_ff <= 1'b0;
        end else if (spi_hdr) begin
            spi_hdr_ff <= 1'b0;
            spi_rd_ff <= spi_rx_byte[`HRFC_HDR_RW_BIT];
        end
    end

    // Register pointer
    always @(posedge clk) begin
        if (!rst_n) begin
            ptr_ff <= 7'h00;
        end else if (ld) begin
            ptr_ff <= hrfc_next(ld_addr, wrap_sel);
        end else if (spi_hdr) begin
            ptr_ff <= spi_rx_byte[6:0];
        end else if (spi_wr || twi_wr_ok) begin
            ptr_ff <= ptr_ff + 7'h01;
        end else if (twi_ptr_ok) begin
            ptr_ff <= twi_ptr_data[6:0];
        end
    end

    // Sample capture and drain count
    always @(posedge clk) begin
        if (!rst_n) begin
            samples_ff <= 6'h00;
            hold_x_ff <= 16'h0000;
            hold_y_ff <= 16'h0000;
            hold_z_ff <= 16'h0000;
            fifo_pop_ff <= 1'b0;
        end else begin
            fifo_pop_ff <= cap_now && !fifo_empty_flag;
            if (spi_start || twi_ptr_ok) begin
                samples_ff <= 6'h00;
            end else if (cap_now) begin
                samples_ff <= samples_ff + 6'h01;
            end
            if (cap_now) begin
                hold_x_ff <= fifo_x;
                hold_y_ff <= fifo_y;
                hold_z_ff <= nxt_z;
            end
        end
    end

    // Read data delivery
    always @(posedge clk) begin
        if (!rst_n) begin
            tx_byte_ff <= 8'h00;
            tx_load_ff <= 1'b0;
            twi_rdata_ff <= 8'h00;
        end else begin
            tx_load_ff <= spi_ld;
            if (spi_ld) begin
                tx_byte_ff <= nxt_rd_byte;
            end
            if (twi_rd_ok) begin
                twi_rdata_ff <= nxt_rd_byte;
            end
        end
    end

    // Feature register and interrupt clearing
    always @(posedge clk) begin
        if (!rst_n) begin
            read_feature_control_ff <= `HRFC_FEAT_RESET;
            int_clear_ff <= 1'b0;
        end else begin
            if ((spi_wr || twi_wr_ok) && ptr_ff == `HRFC_ADDR_FEAT) begin
                read_feature_control_ff <= spi_wr ? spi_rx_byte : twi_wdata;
            end
            int_clear_ff <= (spi_wr && ptr_ff == `HRFC_ADDR_INTST) ||
                (twi_wr_ok && twi_wr_clears && ptr_ff == `HRFC_ADDR_INTST) ||
                (twi_rd_ok && !twi_wr_clears && ptr_ff == `HRFC_ADDR_INTST);
        end
    end

endmodule // hrfc_read_feature

// ===== verif/hrfc_read_feature_properties.sv
// Port assertions for the read feature control block
`timescale 1ns/1ps
module hrfc_rf_props #(
    parameter [5:0] MAX_SAMPLES = 6'h20
) (
    input wire clk,
    input wire rst_n,
    input wire spi_cs_n,
    input wire spi3_select,
    input wire i2c_select,
    input wire serial_out_pin_out,
    input wire serial_out_pin_oe,
    input wire twi_ptr_load,
    input wire [7:0] twi_ptr_data,
    input wire twi_wr,
    input wire twi_rd,
    input wire [7:0] twi_rdata_ff,
    input wire [7:0] int_status,
    input wire [7:0] sys_status,
    input wire int_clear_ff,
    input wire fifo_pop_ff,
    input wire fifo_empty_flag,
    input wire [7:0] read_feature_control_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire wc = read_feature_control_ff[4] & i2c_select;
    wire p9 = twi_ptr_load && twi_ptr_data[6:0] == 7'h09;
    wire s4 = !spi3_select && !i2c_select;

    a_reset_zero: assert property (disable iff (1'b0)
        !rst_n |=> read_feature_control_ff == 8'h00) else $error("feature not cleared");
    a_spi_off: assert property (i2c_select [*4] |-> !serial_out_pin_oe)
        else $error("pin driven with SPI disabled");
    a_token_on: assert property ($fell(spi_cs_n) && s4 && read_feature_control_ff[2]
        |-> ##[2:5] serial_out_pin_oe && serial_out_pin_out == sys_status[7])
        else $error("status token missing");
    a_token_off: assert property ($fell(spi_cs_n) && s4 && !read_feature_control_ff[2]
        |-> ##[2:5] serial_out_pin_oe && !serial_out_pin_out) else $error("token not blank");
    a_three_wire: assert property ($fell(spi_cs_n) && spi3_select
        |-> !serial_out_pin_oe [*8]) else $error("3-wire pin driven in header");
    a_read_clears: assert property (p9 ##1 twi_rd && !wc
        |=> int_clear_ff && twi_rdata_ff == $past(int_status)) else $error("read clear wrong");
    a_read_keeps: assert property (p9 ##1 twi_rd && wc |=> !int_clear_ff)
        else $error("read cleared flags");
    a_write_clears: assert property (p9 ##1 twi_wr && wc |=> int_clear_ff)
        else $error("write did not clear");
    a_pop_full: assert property (fifo_pop_ff |-> !$past(fifo_empty_flag))
        else $error("pop while empty");
    c_frame: cover property ($fell(spi_cs_n));
    c_clear: cover property (int_clear_ff);
    c_pop: cover property (fifo_pop_ff);
endmodule // hrfc_rf_props

bind hrfc_read_feature hrfc_rf_props #(.MAX_SAMPLES(MAX_SAMPLES)) i_hrfc_rf_props (
    .clk(clk),
    .rst_n(rst_n),
    .spi_cs_n(spi_cs_n),
    .spi3_select(spi3_select),
    .i2c_select(i2c_select),
    .serial_out_pin_out(serial_out_pin_out),
    .serial_out_pin_oe(serial_out_pin_oe),
    .twi_ptr_load(twi_ptr_load),
    .twi_ptr_data(twi_ptr_data),
    .twi_wr(twi_wr),
    .twi_rd(twi_rd),
    .twi_rdata_ff(twi_rdata_ff),
    .int_status(int_status),
    .sys_status(sys_status),
    .int_clear_ff(int_clear_ff),
    .fifo_pop_ff(fifo_pop_ff),
    .fifo_empty_flag(fifo_empty_flag),
    .read_feature_control_ff(read_feature_control_ff)
);

// ===== verif/hrfc_host_model.sv
// Host SPI master in mode 0 driving the device pins
`timescale 1ns/1ps
module hrfc_host_model (
    input wire clk,
    input wire sdo,
    output logic sck,
    output logic cs_n,
    output logic mosi
);
    logic [7:0] rx [0:63];
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic half();
        repeat (8) @(negedge clk);
    endtask
    // Header then n bytes; reads leave a toggling line
    task automatic xfer(input logic [7:0] hdr, input int n, input logic [7:0] wd);
        logic [7:0] tx;
        @(negedge clk);
        cs_n = 1'b0;
        half();
        for (int b = 0; b <= n; b++) begin
            tx = (b == 0) ? hdr : wd;
            for (int i = 7; i >= 0; i--) begin
                mosi = (b > 0 && hdr[7]) ? ~mosi : tx[i];
                half();
                sck = 1'b1;
                rx[b][i] = sdo;
                half();
                sck = 1'b0;
            end
        end
        half();
        cs_n = 1'b1;
        mosi = ~mosi;
        half();
        half();
    endtask
endmodule // hrfc_host_model

// ===== verif/tb_top.sv
// Self-checking bench for the read feature control block
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, i2c_select, spi3_select, twi_ptr_load, twi_wr, twi_rd, res_14bit;
    logic interrupt_pending_flag, queue_threshold_flag, fifo_full_flag, fifo_empty_flag;
    logic [7:0] twi_ptr_data, twi_wdata, status1, int_status, sys_status, feat, q;
    logic [15:0] fifo_x, fifo_y, fifo_z;
    logic [31:0] seed = 32'h06C38AFD;
    wire spi_sck, spi_cs_n, spi_mosi, serial_out_pin_in, serial_out_pin_out, serial_out_pin_oe;
    wire int_clear_ff, fifo_pop_ff, outside_trigger_enable, outside_trigger_polarity;
    wire fifo_stream_enable;
    wire [7:0] twi_rdata_ff, read_feature_control_ff;
    int err_count = 0, n_compared = 0, clr_n = 0, pop_n = 0, c0;

    hrfc_read_feature #(.MAX_SAMPLES(6'h04)) i_hrfc_read_feature (
        .clk(clk),
        .rst_n(rst_n),
        .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .serial_out_pin_in(serial_out_pin_in),
        .serial_out_pin_out(serial_out_pin_out),
        .serial_out_pin_oe(serial_out_pin_oe),
        .i2c_select(i2c_select),
        .spi3_select(spi3_select),
        .twi_ptr_load(twi_ptr_load),
        .twi_ptr_data(twi_ptr_data),
        .twi_wr(twi_wr),
        .twi_wdata(twi_wdata),
        .twi_rd(twi_rd),
        .twi_rdata_ff(twi_rdata_ff),
        .fifo_x(fifo_x),
        .fifo_y(fifo_y),
        .fifo_z(fifo_z),
        .res_14bit(res_14bit),
        .interrupt_pending_flag(interrupt_pending_flag),
        .queue_threshold_flag(queue_threshold_flag),
        .fifo_full_flag(fifo_full_flag),
        .fifo_empty_flag(fifo_empty_flag),
        .status1(status1),
        .int_status(int_status),
        .sys_status(sys_status),
        .int_clear_ff(int_clear_ff),
        .fifo_pop_ff(fifo_pop_ff),
        .read_feature_control_ff(read_feature_control_ff),
        .outside_trigger_enable(outside_trigger_enable),
        .outside_trigger_polarity(outside_trigger_polarity),
        .fifo_stream_enable(fifo_stream_enable)
    );
    hrfc_host_model i_hrfc_host_model (.clk(clk), .sdo(serial_out_pin_out), .sck(spi_sck),
        .cs_n(spi_cs_n), .mosi(spi_mosi));
    assign serial_out_pin_in = serial_out_pin_oe ? serial_out_pin_out : spi_mosi;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        clr_n += int_clear_ff;
        pop_n += fifo_pop_ff;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction
    task automatic rnd();
        seed = lfsr(seed);
        {fifo_x, fifo_y} = seed;
        seed = lfsr(seed);
        {fifo_z, status1, int_status} = seed;
        seed = lfsr(seed);
        {sys_status, interrupt_pending_flag, queue_threshold_flag, fifo_full_flag} = seed[10:0];
    endtask
    // Byte port pulse set at a falling edge; returns last cycle's read data
    task automatic twi(input logic [2:0] op, input logic [7:0] d, output logic [7:0] r);
        @(negedge clk);
        r = twi_rdata_ff;
        {twi_ptr_load, twi_wr, twi_rd} = op;
        twi_ptr_data = d;
        twi_wdata = d;
    endtask
    task automatic setf(input logic [7:0] v);
        twi(3'b100, 8'h0E, q);
        twi(3'b010, v, q);
        twi(3'b000, 8'h00, q);
        feat = v;
    endtask
    function automatic logic [7:0] exp_byte(input logic [6:0] a);
        logic [3:0] fl;
        logic [15:0] z;
        logic [63:0] w;
        fl = {interrupt_pending_flag, queue_threshold_flag, fifo_full_flag, fifo_empty_flag};
        z = !feat[3] ? fifo_z : res_14bit ? {fifo_z[15:4], fl} : {fl, fifo_z[11:0]};
        w = {int_status, status1, z, fifo_y, fifo_x};
        return w[(a - 7'h02) * 8 +: 8];
    endfunction
    task automatic burst(input int n);
        logic [6:0] a;
        int f;
        a = 7'h02;
        f = 0;
        c0 = pop_n;
        twi(3'b100, 8'h02, q);
        for (int k = 0; k <= n; k++) begin
            twi(k < n ? 3'b001 : 3'b000, 8'h00, q);
            if (k > 0) begin
                check(q, exp_byte(a));
                f += (a == 7'h02);
                a = (a == (feat[0] ? 7'h09 : 7'h07)) ? 7'h02 : a + 7'h01;
            end
        end
        twi(3'b000, 8'h00, q);
        check(16'(pop_n - c0), fifo_empty_flag ? 0 : feat[1] ? (f < 4 ? f : 4) : 1);
    endtask

    initial begin
        {twi_ptr_load, twi_wr, twi_rd, spi3_select, res_14bit, fifo_empty_flag} = 6'h00;
        {twi_ptr_data, twi_wdata, feat} = 24'h000000;
        i2c_select = 1'b1;
        rnd();
        rst_n = 1'b0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check(read_feature_control_ff, 8'h00);
        check({serial_out_pin_oe, int_clear_ff, fifo_pop_ff}, 16'h0000);
        check({outside_trigger_enable, outside_trigger_polarity, fifo_stream_enable}, 16'h0000);
        repeat (4) @(negedge clk);
        for (int m = 0; m < 8; m++) begin
            rnd();
            fifo_empty_flag = (m == 5);
            res_14bit = m[0] ^ m[1];
            setf({4'h0, m[2] | m[1], m[2], m[1], m[0]});
            burst(m[0] ? 40 : 31);
            $display("burst test %0d done", m);
        end
        fifo_empty_flag = 1'b0;
        for (int m = 0; m < 4; m++) begin
            i2c_select = m[1];
            setf({3'b000, m[0], 4'h0});
            c0 = clr_n;
            twi(3'b100, 8'h09, q);
            twi(3'b001, 8'h00, q);
            twi(3'b000, 8'h00, q);
            twi(3'b000, 8'h00, q);
            check(16'(clr_n - c0), !(m[0] && m[1]));
            check(q, int_status);
            c0 = clr_n;
            twi(3'b100, 8'h09, q);
            twi(3'b010, 8'h5A, q);
            twi(3'b000, 8'h00, q);
            twi(3'b000, 8'h00, q);
            check(16'(clr_n - c0), m[0] && m[1]);
            $display("interrupt clear test %0d done", m);
        end
        i2c_select = 1'b0;
        for (int m = 0; m < 4; m++) begin
            spi3_select = m[1];
            rnd();
            feat = {3'b000, m[0], 1'b0, m[0], 2'b00};
            i_hrfc_host_model.xfer(8'h0E, 1, feat);
            check(read_feature_control_ff, feat);
            i_hrfc_host_model.xfer(8'h82, 2, 8'h00);
            if (!m[1]) check(i_hrfc_host_model.rx[0], m[0] ? sys_status : 8'h00);
            check({i_hrfc_host_model.rx[2], i_hrfc_host_model.rx[1]}, fifo_x);
            c0 = clr_n;
            i_hrfc_host_model.xfer(8'h89, 1, 8'h00);
            check(i_hrfc_host_model.rx[1], int_status);
            check(16'(clr_n - c0), 16'h0000);
            i_hrfc_host_model.xfer(8'h09, 1, 8'hA5);
            check(16'(clr_n - c0), 16'h0001);
            $display("spi test %0d done", m);
        end
        i2c_select = 1'b1;
        c0 = clr_n + pop_n;
        i_hrfc_host_model.xfer(8'h82, 6, 8'h00);
        i_hrfc_host_model.xfer(8'h09, 1, 8'hFF);
        check(16'(clr_n + pop_n - c0), 16'h0000);
        $display("spi disable test done");
        report_and_stop();
    end
    initial begin
        #200000;
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // tb_top
